// File: core/xfi_top.sv
`timescale 1ns/1ps
// Overview of operation
// - receive bonding only with rate matching enabled
// - bonded receive PCS uses central divider clock
// - unbonded: each transmit channel forwards its parallel clock
// - receive forward: recovered, or transmit with ratematch
// - fifo write port clocked by interface clock
// - bonded transmit: only index 0 clock forwarded
// - slow clock underruns, fast clock overflows fifo
// - bonded clock from central divider channel 1/4
// - channel 4 reset removes shared interface clock
// - fifo reads on divided clock, same forwarded
// - receive interface clocked by its interface clock
module xfi_top #(
    parameter int NCH = xfi_pkg::NCH,
    parameter int W = xfi_pkg::DATA_W,
    parameter int DEPTH = xfi_pkg::FIFO_DEPTH,
    parameter int DIV = xfi_pkg::PAR_DIV
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic TX_BOND,
    input wire logic RX_BOND,
    input wire logic RM_EN,
    input wire logic BYTE_SER,
    input wire logic CEN_HI,
    input wire logic USE_CORECLK,
    input wire logic CORECLK_EN,
    input wire logic [NCH-1:0] CH_RST,
    input wire logic [NCH-1:0] REC_CLK,
    input wire logic [W-1:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    output logic [NCH-1:0] TX_CLKOUT_EN,
    output logic [NCH-1:0] RX_CLKOUT_EN,
    output logic [NCH-1:0] RX_RM_RD_EN,
    output logic IF_CLK_EN,
    output logic [W-1:0] PCS_DATA,
    output logic PCS_DV,
    output logic UNDERRUN,
    output logic OVERFLOW,
    output logic IF_LOST,
    output logic RX_BOND_ACT,
    output logic RX_BOND_ERR
);
    localparam int CW = $clog2(DEPTH + 1);

    // ****************************************
    // configuration
    // ****************************************
    logic tx_bond, rm, byte_ser, cen_hi, use_core;
    logic next_tx_bond, next_rm, next_byte_ser, next_cen_hi, next_use_core;
    logic next_rx_bond_act, next_rx_bond_err;

    always_comb begin
        next_tx_bond = TX_BOND;
        next_rm = RM_EN;
        next_byte_ser = BYTE_SER;
        next_cen_hi = CEN_HI;
        next_use_core = USE_CORECLK;
        // bonded receive without rate matching is refused
        next_rx_bond_act = RX_BOND & RM_EN;
        next_rx_bond_err = RX_BOND & ~RM_EN;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_bond <= 1'b0;
            rm <= 1'b0;
            byte_ser <= 1'b0;
            cen_hi <= 1'b0;
            use_core <= 1'b0;
            RX_BOND_ACT <= 1'b0;
            RX_BOND_ERR <= 1'b0;
        end else begin
            tx_bond <= next_tx_bond;
            rm <= next_rm;
            byte_ser <= next_byte_ser;
            cen_hi <= next_cen_hi;
            use_core <= next_use_core;
            RX_BOND_ACT <= next_rx_bond_act;
            RX_BOND_ERR <= next_rx_bond_err;
        end
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [NCH-1:0] rst_m, rst_s, rec_m, rec_s, rec_d, rec_tick;

    // resets held asserted until two clean samples, so a channel starts stopped
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_m <= '1;
            rst_s <= '1;
            rec_m <= '0;
            rec_s <= '0;
            rec_d <= '0;
        end else begin
            rst_m <= CH_RST;
            rst_s <= rst_m;
            rec_m <= REC_CLK;
            rec_s <= rec_m;
            rec_d <= rec_s;
        end
    end

    // recovered clock must be well below CLK/2 for edges to be seen
    assign rec_tick = rec_s & ~rec_d;

    // ****************************************
    // per-channel parallel clock dividers
    // ****************************************
    logic [NCH-1:0] tick;

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_div
            xfi_clk_div #(
                .DIV(DIV)
            ) u_div (
                .clk(CLK),
                .rst_n(RST_N),
                .run(~rst_s[gi]),
                .half(byte_ser),
                .tick(tick[gi])
            );
        end
    endgenerate

    // ****************************************
    // clock forwarding
    // ****************************************
    logic [2:0] cen_ch;
    logic [2:0] src_ch;
    logic cen_tick;
    logic [NCH-1:0] tx_fwd, rx_fwd, rm_rd;

    assign cen_ch = cen_hi ? 3'(xfi_pkg::CH_CEN_HI) : 3'(xfi_pkg::CH_CEN_LO);
    assign cen_tick = tick[cen_ch];

    always_comb begin
        tx_fwd = '0;
        rx_fwd = '0;
        rm_rd = '0;
        for (int i = 0; i < NCH; i++) begin
            if (tx_bond) begin
                // one clock on index 0 serves the whole bonded group
                tx_fwd[i] = (i == 0) ? cen_tick : 1'b0;
            end else begin
                tx_fwd[i] = tick[i];
            end
        end
        for (int i = 0; i < NCH; i++) begin
            if (RX_BOND_ACT) begin
                rx_fwd[i] = (i == 0) ? tx_fwd[0] : 1'b0;
                rm_rd[i] = cen_tick;
            end else begin
                rx_fwd[i] = rm ? tx_fwd[i] : rec_tick[i];
                rm_rd[i] = tick[i];
            end
        end
    end

    // ****************************************
    // interface clock selection
    // ****************************************
    logic src_lost, wr_tick, rd_tick;

    // with core clock the fabric is assumed to reuse the channel 4 clock
    assign src_ch = use_core ? 3'(xfi_pkg::CH_SHARE) : (tx_bond ? cen_ch : 3'h0);
    assign src_lost = rst_s[src_ch] | rst_s[xfi_pkg::CH_DATA];
    // forwarded write clock is index 0: own tick when solo, central tick when bonded
    assign wr_tick = ~src_lost & (use_core ? CORECLK_EN : tx_fwd[xfi_pkg::CH_DATA]);
    assign rd_tick = tx_fwd[xfi_pkg::CH_DATA] | (tx_bond & cen_tick);

    // ****************************************
    // phase-compensation fifo
    // ****************************************
    xfi_fifo_if #(.W(W), .CW(CW)) f ();

    xfi_fifo #(
        .W(W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(CLK),
        .rst_n(RST_N),
        .f(f.fifo)
    );

    xfi_pkg::xfi_if_st_t st, next_st;
    logic pop, under, over;
    logic next_under, next_over, next_lost;

    assign pop = (st == xfi_pkg::XFI_IF_RUN) & rd_tick & f.rd_valid;
    assign f.wr_valid = TX_VALID & wr_tick;
    assign f.wr_data = TX_DATA;
    assign f.rd_ready = pop;

    always_comb begin
        next_st = st;
        case (st)
            xfi_pkg::XFI_IF_IDLE: begin
                if (!src_lost) begin
                    next_st = xfi_pkg::XFI_IF_FILL;
                end
            end
            xfi_pkg::XFI_IF_FILL: begin
                // a small lead keeps read from chasing write too closely
                if (src_lost) begin
                    next_st = xfi_pkg::XFI_IF_IDLE;
                end else if (f.count >= CW'(xfi_pkg::FILL_LEVEL)) begin
                    next_st = xfi_pkg::XFI_IF_RUN;
                end
            end
            xfi_pkg::XFI_IF_RUN: begin
                if (src_lost) begin
                    next_st = xfi_pkg::XFI_IF_IDLE;
                end
            end
            default: begin
                next_st = xfi_pkg::XFI_IF_IDLE;
            end
        endcase
        under = (st == xfi_pkg::XFI_IF_RUN) & rd_tick & ~f.rd_valid;
        over = wr_tick & TX_VALID & ~f.wr_ready;
        next_under = under;
        next_over = over;
        next_lost = src_lost;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st <= xfi_pkg::XFI_IF_IDLE;
            UNDERRUN <= 1'b0;
            OVERFLOW <= 1'b0;
            IF_LOST <= 1'b1;
        end else begin
            st <= next_st;
            UNDERRUN <= next_under;
            OVERFLOW <= next_over;
            IF_LOST <= next_lost;
        end
    end

    // ****************************************
    // registered clock outputs
    // ****************************************
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            TX_CLKOUT_EN <= '0;
            RX_CLKOUT_EN <= '0;
            RX_RM_RD_EN <= '0;
            IF_CLK_EN <= 1'b0;
        end else begin
            TX_CLKOUT_EN <= tx_fwd;
            RX_CLKOUT_EN <= rx_fwd;
            RX_RM_RD_EN <= rm_rd;
            IF_CLK_EN <= wr_tick;
        end
    end

    assign TX_READY = f.wr_ready;
    assign PCS_DATA = f.rd_data;
    assign PCS_DV = f.rd_dv;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    property p_rx_bond_legal;
        RX_BOND_ACT |-> $past(RM_EN) && !RX_BOND_ERR;
    endproperty
    a_rx_bond_legal: assert property (p_rx_bond_legal) else $error("bonded rx without rm");

    property p_rx_bond_central;
        RX_BOND_ACT |=> RX_RM_RD_EN == {NCH{$past(cen_tick)}};
    endproperty
    a_rx_bond_central: assert property (p_rx_bond_central) else $error("rx pcs off central");

    property p_tx_solo_fwd;
        !tx_bond |=> TX_CLKOUT_EN == $past(tick);
    endproperty
    a_tx_solo_fwd: assert property (p_tx_solo_fwd) else $error("tx clock not forwarded");

    property p_rx_fwd_sel;
        !RX_BOND_ACT && rm |=> RX_CLKOUT_EN == $past(tx_fwd);
    endproperty
    a_rx_fwd_sel: assert property (p_rx_fwd_sel) else $error("rx forward wrong source");

    property p_wr_only_tick;
        f.count > $past(f.count) |-> $past(wr_tick) && $past(TX_VALID);
    endproperty
    a_wr_only_tick: assert property (p_wr_only_tick) else $error("write off interface clock");

    property p_tx_bond_idx0;
        tx_bond |=> TX_CLKOUT_EN == {{(NCH-1){1'b0}}, $past(cen_tick)};
    endproperty
    a_tx_bond_idx0: assert property (p_tx_bond_idx0) else $error("bonded tx not on index 0");

    property p_overflow;
        wr_tick && TX_VALID && !TX_READY |=> OVERFLOW;
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow not flagged");

    property p_underrun;
        st == xfi_pkg::XFI_IF_RUN && rd_tick && f.count == '0 |=> UNDERRUN && !PCS_DV;
    endproperty
    a_underrun: assert property (p_underrun) else $error("underrun not flagged");

    property p_share_lost;
        use_core && rst_s[xfi_pkg::CH_SHARE] |=> !IF_CLK_EN && IF_LOST;
    endproperty
    a_share_lost: assert property (p_share_lost) else $error("shared clock not removed");

    property p_read_divided;
        PCS_DV |-> $past(rd_tick) && $past(st) == xfi_pkg::XFI_IF_RUN;
    endproperty
    a_read_divided: assert property (p_read_divided) else $error("read off divided clock");

    c_bond_tx: cover property (tx_bond && PCS_DV);
    c_underrun: cover property (UNDERRUN);
    c_overflow: cover property (OVERFLOW);
    c_share_lost: cover property (use_core ##1 IF_LOST);
endmodule

// File: inc/xfi_pkg.sv
package xfi_pkg;

    // ****************************************
    // sizes
    // ****************************************
    localparam int NCH = 6;
    localparam int DATA_W = 16;
    localparam int FIFO_DEPTH = 16;

    // ****************************************
    // clocking
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    // system clock cycles per parallel clock period
    localparam int PAR_DIV = 4;
    localparam logic [7:0] DIV_CNT_RST = 8'h00;
    // channels that may hold the central divider
    localparam int CH_CEN_LO = 1;
    localparam int CH_CEN_HI = 4;
    // channel whose forwarded clock is shared over the user core-clock inputs
    localparam int CH_SHARE = 4;
    // channel whose transmit datapath the fifo serves
    localparam int CH_DATA = 0;

    // ****************************************
    // phase-compensation fifo
    // ****************************************
    // words held before the read side starts
    localparam int FILL_LEVEL = 2;
    localparam logic [15:0] DATA_RST = 16'h0000;

    typedef enum logic [1:0] {XFI_IF_IDLE, XFI_IF_FILL, XFI_IF_RUN} xfi_if_st_t;

endpackage

// File: inc/xfi_fifo_if.sv
`timescale 1ns/1ps
interface xfi_fifo_if #(
    parameter int W = 16,
    parameter int CW = 5
);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_ready;
    logic rd_valid;
    logic rd_dv;
    logic [W-1:0] rd_data;
    logic [CW-1:0] count;

    modport fifo (
        input wr_valid, wr_data, rd_ready,
        output wr_ready, rd_valid, rd_dv, rd_data, count
    );
    modport user (
        output wr_valid, wr_data, rd_ready,
        input wr_ready, rd_valid, rd_dv, rd_data, count
    );
endinterface

// File: core/xfi_clk_div.sv
`timescale 1ns/1ps
module xfi_clk_div #(
    parameter int DIV = xfi_pkg::PAR_DIV
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic half,
    output logic tick
);
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [7:0] lim;
    logic next_tick;

    // byte serializer halves the rate seen by the fifo read side
    assign lim = half ? 8'(2 * DIV - 1) : 8'(DIV - 1);

    always_comb begin
        next_cnt = cnt;
        next_tick = 1'b0;
        if (!run) begin
            // channel in reset or powered down: clock stops
            next_cnt = xfi_pkg::DIV_CNT_RST;
        end else if (cnt >= lim) begin
            next_cnt = xfi_pkg::DIV_CNT_RST;
            next_tick = 1'b1;
        end else begin
            next_cnt = cnt + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= xfi_pkg::DIV_CNT_RST;
            tick <= 1'b0;
        end else begin
            cnt <= next_cnt;
            tick <= next_tick;
        end
    end
endmodule

// File: core/xfi_fifo.sv
`timescale 1ns/1ps
module xfi_fifo #(
    parameter int W = xfi_pkg::DATA_W,
    parameter int DEPTH = xfi_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    xfi_fifo_if.fifo f
);
    // depth must be a power of two: pointers wrap by overflow
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wp, rp, next_wp, next_rp;
    logic [CW-1:0] cnt, next_cnt;
    logic rdy, next_rdy, dv, next_dv;
    logic [W-1:0] dout, next_dout;
    logic push, pop;

    assign push = f.wr_valid & rdy;
    assign pop = f.rd_ready & (cnt != '0);

    always_comb begin
        next_wp = wp + AW'(push);
        next_rp = rp + AW'(pop);
        next_cnt = cnt + CW'(push) - CW'(pop);
        next_rdy = next_cnt < CW'(DEPTH);
        next_dv = pop;
        next_dout = pop ? mem[rp] : dout;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp <= '0;
            rp <= '0;
            cnt <= '0;
            rdy <= 1'b1;
            dv <= 1'b0;
            dout <= '0;
        end else begin
            wp <= next_wp;
            rp <= next_rp;
            cnt <= next_cnt;
            rdy <= next_rdy;
            dv <= next_dv;
            dout <= next_dout;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp] <= f.wr_data;
        end
    end

    assign f.wr_ready = rdy;
    assign f.rd_valid = cnt != '0;
    assign f.rd_dv = dv;
    assign f.rd_data = dout;
    assign f.count = cnt;

    // ****************************************
    // checks
    // ****************************************
    property p_fifo_bound;
        @(posedge clk) disable iff (!rst_n)
        cnt <= CW'(DEPTH);
    endproperty
    a_fifo_bound: assert property (p_fifo_bound) else $error("fifo count beyond depth");

    property p_fifo_no_dup;
        @(posedge clk) disable iff (!rst_n)
        dv |-> $past(cnt) != '0 && cnt == $past(cnt) - CW'(1) + CW'($past(push));
    endproperty
    a_fifo_no_dup: assert property (p_fifo_no_dup) else $error("word read from empty fifo");
endmodule

// File: sim/xfi_fabric_model.sv
`timescale 1ns/1ps
// ****************************************
// fabric-side writer for the transmit interface
// ****************************************
module xfi_fabric_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [1:0] mode,
    input wire logic use_core,
    input wire logic [xfi_pkg::NCH-1:0] fwd_en,
    input wire logic if_clk_en,
    input wire logic tx_ready,
    output logic core_en,
    output logic [xfi_pkg::DATA_W-1:0] tx_data,
    output logic tx_valid
);
    logic rdy0;
    logic ph;

    // ready as it stood at the edge that if_clk_en reports
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdy0 <= 1'b1;
        end else begin
            rdy0 <= tx_ready;
        end
    end

    // mode 0 follows channel 4, 1 runs too fast, 2 too slow
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_data <= 16'h0001;
            tx_valid <= 1'b0;
            core_en <= 1'b0;
            ph <= 1'b0;
        end else begin
            tx_valid <= 1'b1;
            // word held until taken; if_clk_en leaves out ticks lost to channel reset
            if (if_clk_en && rdy0) begin
                tx_data <= tx_data + 16'h0001;
            end
            case (mode)
                2'd1: core_en <= 1'b1;
                2'd2: begin
                    if (fwd_en[xfi_pkg::CH_SHARE]) begin
                        ph <= !ph;
                        core_en <= ph;
                    end else begin
                        core_en <= 1'b0;
                    end
                end
                default: core_en <= use_core & fwd_en[xfi_pkg::CH_SHARE];
            endcase
        end
    end
endmodule

// File: sim/xfi_top_tb_top.sv
`timescale 1ns/1ps
module xfi_top_tb_top;
    localparam int NCH = xfi_pkg::NCH;
    localparam int DIV = 4;
    logic CLK, RST_N, TX_BOND, RX_BOND, RM_EN, BYTE_SER, CEN_HI, USE_CORECLK, CORECLK_EN;
    logic [NCH-1:0] CH_RST, REC_CLK, TX_CLKOUT_EN, RX_CLKOUT_EN, RX_RM_RD_EN;
    logic [xfi_pkg::DATA_W-1:0] TX_DATA, PCS_DATA, exp_word;
    logic TX_VALID, TX_READY, IF_CLK_EN, PCS_DV, UNDERRUN, OVERFLOW, IF_LOST;
    logic RX_BOND_ACT, RX_BOND_ERR;
    logic [1:0] mode;
    int n_fail, cmp_count, cyc, last0, exp_gap, gap_bad, n_un, n_ov, n_if, n_dv, n_nrdy, n_split;
    int n_tx[NCH];
    int n_rx[NCH];

    xfi_top #(.DIV(DIV)) xfi_top_i (.CLK(CLK), .RST_N(RST_N), .TX_BOND(TX_BOND),
        .RX_BOND(RX_BOND), .RM_EN(RM_EN), .BYTE_SER(BYTE_SER), .CEN_HI(CEN_HI),
        .USE_CORECLK(USE_CORECLK), .CORECLK_EN(CORECLK_EN), .CH_RST(CH_RST),
        .REC_CLK(REC_CLK), .TX_DATA(TX_DATA), .TX_VALID(TX_VALID), .TX_READY(TX_READY),
        .TX_CLKOUT_EN(TX_CLKOUT_EN), .RX_CLKOUT_EN(RX_CLKOUT_EN), .RX_RM_RD_EN(RX_RM_RD_EN),
        .IF_CLK_EN(IF_CLK_EN), .PCS_DATA(PCS_DATA), .PCS_DV(PCS_DV), .UNDERRUN(UNDERRUN),
        .OVERFLOW(OVERFLOW), .IF_LOST(IF_LOST), .RX_BOND_ACT(RX_BOND_ACT),
        .RX_BOND_ERR(RX_BOND_ERR));

    xfi_fabric_model xfi_fabric_model_i (.clk(CLK), .rst_n(RST_N), .mode(mode),
        .use_core(USE_CORECLK), .fwd_en(TX_CLKOUT_EN), .if_clk_en(IF_CLK_EN),
        .tx_ready(TX_READY), .core_en(CORECLK_EN), .tx_data(TX_DATA), .tx_valid(TX_VALID));

    // ****************************************
    // compare and closing
    // ****************************************
    task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (exp !== got) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk_int(input string name, input int exp, input int got);
        cmp_count++;
        if (exp != got) begin
            n_fail++;
            $display("BAD %s expected %0d seen %0d", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ****************************************
    // monitors
    // ****************************************
    always @(negedge CLK) begin
        cyc++;
        if (RST_N === 1'b1) begin
            for (int i = 0; i < NCH; i++) begin
                n_tx[i] += int'(TX_CLKOUT_EN[i] === 1'b1);
                n_rx[i] += int'(RX_CLKOUT_EN[i] === 1'b1);
            end
            n_un += int'(UNDERRUN === 1'b1);
            n_ov += int'(OVERFLOW === 1'b1);
            n_if += int'(IF_CLK_EN === 1'b1);
            n_nrdy += int'(TX_READY === 1'b0);
            n_split += int'(RX_RM_RD_EN !== '0 && RX_RM_RD_EN !== '1);
            if (TX_CLKOUT_EN[0] === 1'b1) begin
                gap_bad += int'(last0 >= 0 && cyc - last0 != exp_gap);
                last0 = cyc;
            end
            if (PCS_DV === 1'b1) begin
                n_dv++;
                chk_word("pcs_data", exp_word, PCS_DATA);
                exp_word = exp_word + 16'h0001;
            end
        end
    end

    // window boundaries on the rising edge keep clear and count apart
    task automatic win(input int n, input int gap);
        @(posedge CLK);
        n_tx = '{default: 0};
        n_rx = '{default: 0};
        {n_un, n_ov, n_if, n_dv, n_nrdy, n_split, gap_bad} = '0;
        last0 = -1;
        exp_gap = gap;
        repeat (n) @(posedge CLK);
    endtask

    task automatic do_reset();
        @(negedge CLK);
        RST_N = 1'b0;
        exp_word = 16'h0001;
        repeat (6) @(negedge CLK);
        chk_word("ready_in_reset", 16'h0001, 16'(TX_READY));
        chk_word("lost_in_reset", 16'h0001, 16'(IF_LOST));
        chk_word("dv_in_reset", 16'h0000, 16'(PCS_DV));
        RST_N = 1'b1;
        repeat (20) @(negedge CLK);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_solo();
        {TX_BOND, RX_BOND, RM_EN, BYTE_SER, USE_CORECLK} = 5'b00100;
        do_reset();
        win(160, DIV);
        for (int i = 0; i < NCH; i++) begin
            chk_int("tx_fwd", 40, n_tx[i]);
            chk_int("rx_fwd_rm", 40, n_rx[i]);
        end
        chk_int("tx_gap", 0, gap_bad);
        chk_int("flow", 1, int'(n_dv >= 35));
        chk_int("slips", 0, n_un + n_ov);
        @(negedge CLK);
        BYTE_SER = 1'b1;
        RM_EN = 1'b0;
        win(20, 2 * DIV);
        win(160, 2 * DIV);
        chk_int("tx_fwd_ser", 20, n_tx[0]);
        chk_int("ser_gap", 0, gap_bad);
        @(negedge CLK);
        win(0, DIV);
        // odd channels get five recovered edges, even ones none
        for (int k = 0; k < 10; k++) begin
            @(negedge CLK);
            REC_CLK = REC_CLK ^ 6'h2A;
            repeat (3) @(negedge CLK);
        end
        repeat (10) @(negedge CLK);
        @(posedge CLK);
        for (int i = 0; i < NCH; i++) begin
            chk_int("rx_fwd_rec", (i % 2) ? 5 : 0, n_rx[i]);
        end
        @(negedge CLK);
        REC_CLK = '0;
    endtask

    task automatic t_bond();
        {TX_BOND, RX_BOND, RM_EN, BYTE_SER, USE_CORECLK, CEN_HI} = 6'b111001;
        do_reset();
        win(160, DIV);
        chk_int("bond_tx0", 40, n_tx[0]);
        chk_int("bond_rx0", 40, n_rx[0]);
        for (int i = 1; i < NCH; i++) begin
            chk_int("bond_txn", 0, n_tx[i]);
            chk_int("bond_rxn", 0, n_rx[i]);
        end
        chk_int("bond_gap", 0, gap_bad);
        chk_int("rm_rd_split", 0, n_split);
        chk_int("bond_flow", 1, int'(n_dv >= 35));
        @(negedge CLK);
        chk_word("bond_act", 16'h0002, 16'({RX_BOND_ACT, RX_BOND_ERR}));
        RM_EN = 1'b0;
        repeat (3) @(negedge CLK);
        chk_word("bond_err", 16'h0002, 16'({RX_BOND_ERR, RX_BOND_ACT}));
        // channel 1 down: harmless with the divider in channel 4, fatal without
        CH_RST = 6'h02;
        win(20, DIV);
        win(80, DIV);
        chk_int("cen4_alive", 1, int'(n_if >= 18));
        @(negedge CLK);
        CEN_HI = 1'b0;
        win(20, DIV);
        win(80, DIV);
        chk_int("cen1_dead", 0, n_if);
        @(negedge CLK);
        chk_word("cen1_lost", 16'h0001, 16'(IF_LOST));
        CH_RST = '0;
    endtask

    task automatic t_share();
        {TX_BOND, RX_BOND, RM_EN, USE_CORECLK, CEN_HI} = 5'b00011;
        mode = 2'd0;
        do_reset();
        win(160, DIV);
        chk_int("share_ticks", 40, n_if);
        chk_int("share_slips", 0, n_un + n_ov);
        chk_int("share_flow", 1, int'(n_dv >= 35));
        @(negedge CLK);
        CH_RST = 6'h10;
        win(10, DIV);
        win(80, DIV);
        chk_int("share_lost_ticks", 0, n_if);
        @(negedge CLK);
        chk_word("share_lost", 16'h0001, 16'(IF_LOST));
        CH_RST = '0;
    endtask

    task automatic t_ppm();
        mode = 2'd1;
        do_reset();
        win(200, DIV);
        chk_int("fast_overflow", 1, int'(n_ov > 0));
        chk_int("fast_full", 1, int'(n_nrdy > 0));
        @(negedge CLK);
        mode = 2'd2;
        do_reset();
        win(300, DIV);
        chk_int("slow_underrun", 1, int'(n_un > 0));
        @(negedge CLK);
        mode = 2'd0;
    endtask

    // ****************************************
    // clock, watchdog, main
    // ****************************************
    initial begin
        CLK = 1'b0;
        forever #50 CLK = ~CLK;
    end

    initial begin
        repeat (20000) @(posedge CLK);
        n_fail++;
        $display("BAD watchdog expected end seen hang");
        test_done();
    end

    initial begin
        {RST_N, TX_BOND, RX_BOND, RM_EN, BYTE_SER, CEN_HI, USE_CORECLK} = '0;
        {CH_RST, REC_CLK, mode, n_fail, cmp_count, cyc} = '0;
        n_tx = '{default: 0};
        n_rx = '{default: 0};
        {n_un, n_ov, n_if, n_dv, n_nrdy, n_split, gap_bad, exp_gap} = '0;
        last0 = -1;
        exp_word = 16'h0001;
        t_solo();
        t_bond();
        t_share();
        t_ppm();
        test_done();
    end
endmodule
